// ===== logic/cab_alu.sv
// Purpose: 8-bit arithmetic, logic and shift unit with flag update
// Assumes: caller selects operands and carry-in per operation
// Notes:   purely combinational; flags not named by the mode pass through
`timescale 1ns/1ps
`default_nettype none
module cab_alu
   import cab_pkg::*;
(
   input  wire logic [7:0] a,
   input  wire logic [7:0] b,
   input  wire logic       cin,
   input  wire logic       keep_z,
   input  wire cab_alu_t   mode,
   input  wire logic [7:0] status_register_in,
   output logic      [7:0] res,
   output logic      [7:0] status_register_out
);

   logic upd_zn;
   logic upd_s;

   always_comb
   begin
      res      = b;
      status_register_out = status_register_in;
      upd_zn   = 1'b1;
      upd_s    = 1'b1;
      unique case (mode)
         cab_alu_pass,
         cab_alu_swap:
         begin
            res    = (mode == cab_alu_swap) ? {a[3:0], a[7:4]} : b;
            upd_zn = 1'b0;
            upd_s  = 1'b0;
         end
         cab_alu_add:
         begin
            res = a + b + {7'h00, cin};
            status_register_out[CAB_FLG_C] = (a[7] & b[7]) | (b[7] & ~res[7])
                                | (~res[7] & a[7]);
            status_register_out[CAB_FLG_H] = (a[3] & b[3]) | (b[3] & ~res[3])
                                | (~res[3] & a[3]);
            status_register_out[CAB_FLG_V] = (a[7] & b[7] & ~res[7])
                                | (~a[7] & ~b[7] & res[7]);
         end
         cab_alu_sub:
         begin
            res = a - b - {7'h00, cin};
            status_register_out[CAB_FLG_C] = (~a[7] & b[7]) | (b[7] & res[7])
                                | (res[7] & ~a[7]);
            status_register_out[CAB_FLG_H] = (~a[3] & b[3]) | (b[3] & res[3])
                                | (res[3] & ~a[3]);
            status_register_out[CAB_FLG_V] = (a[7] & ~b[7] & ~res[7])
                                | (~a[7] & b[7] & res[7]);
         end
         cab_alu_and,
         cab_alu_or,
         cab_alu_xor:
         begin
            res = (mode == cab_alu_and) ? (a & b) :
                  (mode == cab_alu_or)  ? (a | b) : (a ^ b);
            status_register_out[CAB_FLG_V] = 1'b0;
         end
         cab_alu_com:
         begin
            res = 8'hff - a;
            status_register_out[CAB_FLG_C] = 1'b1;
            status_register_out[CAB_FLG_V] = 1'b0;
         end
         cab_alu_inc:
         begin
            res = a + 8'h01;
            status_register_out[CAB_FLG_V] = (res == 8'h80);
         end
         cab_alu_dec:
         begin
            res = a - 8'h01;
            status_register_out[CAB_FLG_V] = (res == 8'h7f);
         end
         cab_alu_shl:
         begin
            res   = {a[6:0], cin};
            upd_s = 1'b0;
            status_register_out[CAB_FLG_C] = a[7];
            status_register_out[CAB_FLG_H] = a[3];
            status_register_out[CAB_FLG_V] = res[7] ^ a[7];
         end
         cab_alu_shr,
         cab_alu_asr:
         begin
            res   = (mode == cab_alu_asr) ? {a[7], a[7:1]} : {cin, a[7:1]};
            upd_s = 1'b0;
            status_register_out[CAB_FLG_C] = a[0];
            status_register_out[CAB_FLG_V] = res[7] ^ a[0];
         end
      endcase
      if (upd_zn)
      begin
         // carry-chained subtract keeps zero only if the chain stayed zero
         status_register_out[CAB_FLG_Z] = (res == 8'h00)
                             & (~keep_z | status_register_in[CAB_FLG_Z]);
         status_register_out[CAB_FLG_N] = res[7];
      end
      if (upd_s)
         status_register_out[CAB_FLG_S] = status_register_out[CAB_FLG_N] ^ status_register_out[CAB_FLG_V];
   end

endmodule // cab_alu
`default_nettype wire

// ===== logic/cab_exec_top.sv
// Purpose: execution datapath with program-counter control over APB
// Assumes: one operation at a time, launched by a command write
// Notes:   register writes are refused while an operation is running
`timescale 1ns/1ps
`default_nettype none
module cab_exec_top
   import cab_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  io_rdata,
   output logic      [4:0]  io_addr
);

   typedef struct packed {
      logic              pready;
      logic              pslverr;
      logic [31:0]       prdata;
      logic [7:0]        dest;
      logic [7:0]        src;
      logic [11:0]       offs;
      logic [15:0]       zptr;
      logic [7:0]        status;
      logic [7:0]        result;
      logic [21:0]       pc;
      cab_op_t           op;
      logic [2:0]        bsel;
      logic              two_word;
      logic [4:0]        io_a;
      logic              busy;
      logic [2:0]        cnt;
      logic [2:0]        last_cyc;
      logic [2:0]        sp;
      logic [7:0][21:0]  stack;
   } cab_state_t;

   cab_state_t  s_q;
   cab_state_t  s_d;

   logic [7:0]  alu_a;
   logic [7:0]  alu_b;
   logic        alu_cin;
   logic        keep_z;
   cab_alu_t    alu_mode;
   logic [7:0]  alu_res;
   logic [7:0]  alu_status_register;
   logic        wr_dest;
   logic        wr_flags;
   logic        cond;
   cab_pc_t     pc_kind;
   logic [2:0]  cyc;
   logic        carry;
   logic [21:0] pc_rel;
   logic [21:0] pc_next;
   logic        setup;
   logic        access;
   logic        known;
   logic        read_only;
   logic [31:0] rd_mux;

   cab_alu u_alu (
      .a        (alu_a),
      .b        (alu_b),
      .cin      (alu_cin),
      .keep_z   (keep_z),
      .mode     (alu_mode),
      .status_register_in  (s_q.status),
      .res      (alu_res),
      .status_register_out (alu_status_register)
   );

   // operation decode from the latched command
   always_comb
   begin
      carry    = s_q.status[CAB_FLG_C];
      alu_mode = cab_alu_pass;
      alu_a    = s_q.dest;
      alu_b    = s_q.src;
      alu_cin  = 1'b0;
      keep_z   = 1'b0;
      wr_dest  = 1'b0;
      wr_flags = 1'b0;
      cond     = 1'b0;
      pc_kind  = cab_pc_seq;
      cyc      = CAB_CYC_ONE;
      unique case (s_q.op)
         add_op,
         add_carry_op:
         begin
            alu_mode = cab_alu_add;
            alu_cin  = (s_q.op == add_carry_op) & carry;
            wr_dest  = 1'b1;
            wr_flags = 1'b1;
         end
         sub_op,
         sub_imm_op,
         sub_carry_op,
         sub_imm_with_carry_op:
         begin
            alu_mode = cab_alu_sub;
            keep_z   = (s_q.op == sub_carry_op)
                     | (s_q.op == sub_imm_with_carry_op);
            alu_cin  = keep_z & carry;
            wr_dest  = 1'b1;
            wr_flags = 1'b1;
         end
         and_op,
         and_imm_op,
         test_op:
         begin
            alu_mode = cab_alu_and;
            alu_b    = (s_q.op == test_op) ? s_q.dest : s_q.src;
            wr_dest  = 1'b1;
            wr_flags = 1'b1;
         end
         or_op,
         or_imm_op,
         set_bits_mask_op:
         begin
            alu_mode = cab_alu_or;
            wr_dest  = 1'b1;
            wr_flags = 1'b1;
         end
         xor_op,
         clear_reg_op:
         begin
            alu_mode = cab_alu_xor;
            alu_b    = (s_q.op == clear_reg_op) ? s_q.dest : s_q.src;
            wr_dest  = 1'b1;
            wr_flags = 1'b1;
         end
         ones_complement_op:
         begin
            alu_mode = cab_alu_com;
            wr_dest  = 1'b1;
            wr_flags = 1'b1;
         end
         twos_complement_op:
         begin
            alu_mode = cab_alu_sub;
            alu_a    = 8'h00;
            alu_b    = s_q.dest;
            wr_dest  = 1'b1;
            wr_flags = 1'b1;
         end
         clear_bits_mask_op:
         begin
            alu_mode = cab_alu_and;
            alu_b    = 8'hff - s_q.src;
            wr_dest  = 1'b1;
            wr_flags = 1'b1;
         end
         increment_op,
         decrement_op:
         begin
            alu_mode = (s_q.op == increment_op) ? cab_alu_inc
                                                : cab_alu_dec;
            wr_dest  = 1'b1;
            wr_flags = 1'b1;
         end
         set_reg_op:
         begin
            alu_b   = 8'hff;
            wr_dest = 1'b1;
         end
         swap_nibbles_op:
         begin
            alu_mode = cab_alu_swap;
            wr_dest  = 1'b1;
         end
         shift_left_op,
         rotate_left_op:
         begin
            alu_mode = cab_alu_shl;
            alu_cin  = (s_q.op == rotate_left_op) & carry;
            wr_dest  = 1'b1;
            wr_flags = 1'b1;
         end
         shift_right_op,
         rotate_right_op,
         arith_right_shift_op:
         begin
            alu_mode = (s_q.op == arith_right_shift_op) ? cab_alu_asr
                                                        : cab_alu_shr;
            alu_cin  = (s_q.op == rotate_right_op) & carry;
            wr_dest  = 1'b1;
            wr_flags = 1'b1;
         end
         compare_op,
         compare_imm_op,
         compare_carry_op:
         begin
            alu_mode = cab_alu_sub;
            keep_z   = (s_q.op == compare_carry_op);
            alu_cin  = keep_z & carry;
            wr_flags = 1'b1;
         end
         relative_jump_op:
         begin
            pc_kind = cab_pc_rel;
            cyc     = CAB_CYC_JUMP;
         end
         pointer_jump_op:
         begin
            pc_kind = cab_pc_ptr;
            cyc     = CAB_CYC_JUMP;
         end
         relative_call_op:
         begin
            pc_kind = cab_pc_rel_call;
            cyc     = CAB_CYC_CALL;
         end
         pointer_call_op:
         begin
            pc_kind = cab_pc_ptr_call;
            cyc     = CAB_CYC_CALL;
         end
         sub_return_op,
         interrupt_return_op:
         begin
            pc_kind = cab_pc_ret;
            cyc     = CAB_CYC_RET;
         end
         compare_skip_equal_op:
         begin
            pc_kind = cab_pc_skip;
            cond    = (s_q.dest == s_q.src);
         end
         reg_bit_clear_skip_op,
         reg_bit_set_skip_op:
         begin
            pc_kind = cab_pc_skip;
            cond    = s_q.dest[s_q.bsel] == (s_q.op == reg_bit_set_skip_op);
         end
         io_bit_clear_skip_op,
         io_bit_set_skip_op:
         begin
            pc_kind = cab_pc_skip;
            cond    = io_rdata[s_q.bsel] == (s_q.op == io_bit_set_skip_op);
         end
         flag_set_branch_op,
         flag_clear_branch_op:
         begin
            pc_kind = cab_pc_cond_rel;
            cond    = s_q.status[s_q.bsel]
                      == (s_q.op == flag_set_branch_op);
         end
         signed_ge_branch_op,
         signed_lt_branch_op:
         begin
            pc_kind = cab_pc_cond_rel;
            cond    = (s_q.status[CAB_FLG_N] ^ s_q.status[CAB_FLG_V])
                      == (s_q.op == signed_lt_branch_op);
         end
         unsigned_ge_branch_op,
         unsigned_lt_branch_op:
         begin
            pc_kind = cab_pc_cond_rel;
            cond    = carry == (s_q.op == unsigned_lt_branch_op);
         end
         default:
         begin
            wr_dest = 1'b0;
         end
      endcase
      if (pc_kind == cab_pc_skip)
         cyc = !cond ? CAB_CYC_ONE
             : s_q.two_word ? CAB_CYC_SKIP_TWO : CAB_CYC_SKIP_ONE;
      else if (pc_kind == cab_pc_cond_rel)
         cyc = cond ? CAB_CYC_BR_TAKEN : CAB_CYC_ONE;
   end

   // next program counter
   always_comb
   begin
      pc_rel = s_q.pc + {{10{s_q.offs[11]}}, s_q.offs} + 22'd1;
      unique case (pc_kind)
         cab_pc_seq:      pc_next = s_q.pc + 22'd1;
         cab_pc_rel,
         cab_pc_rel_call: pc_next = pc_rel;
         cab_pc_cond_rel: pc_next = cond ? pc_rel : s_q.pc + 22'd1;
         cab_pc_ptr,
         cab_pc_ptr_call: pc_next = {6'h00, s_q.zptr};
         cab_pc_ret:      pc_next = s_q.stack[s_q.sp - 3'd1];
         cab_pc_skip:     pc_next = !cond ? s_q.pc + 22'd1
                                  : s_q.two_word ? s_q.pc + 22'd3
                                  : s_q.pc + 22'd2;
      endcase
   end

   // register read mux and decode
   always_comb
   begin
      known     = 1'b1;
      read_only = 1'b0;
      rd_mux    = 32'h0000_0000;
      unique case (paddr)
         CAB_ADDR_CMD:
         begin
            rd_mux[CAB_CMD_OP_LSB +: 6]  = s_q.op;
            rd_mux[CAB_CMD_BIT_LSB +: 3] = s_q.bsel;
            rd_mux[CAB_CMD_TWO_POS]      = s_q.two_word;
            rd_mux[CAB_CMD_IO_LSB +: 5]  = s_q.io_a;
         end
         CAB_ADDR_DEST:   rd_mux[7:0]  = s_q.dest;
         CAB_ADDR_SRC:    rd_mux[7:0]  = s_q.src;
         CAB_ADDR_OFFS:   rd_mux[11:0] = s_q.offs;
         CAB_ADDR_ZPTR:   rd_mux[15:0] = s_q.zptr;
         CAB_ADDR_STATUS: rd_mux[7:0]  = s_q.status;
         CAB_ADDR_PC:     rd_mux[21:0] = s_q.pc;
         CAB_ADDR_RESULT:
         begin
            rd_mux[7:0] = s_q.result;
            read_only   = 1'b1;
         end
         CAB_ADDR_STATE:
         begin
            rd_mux[CAB_ST_BUSY_POS]     = s_q.busy;
            rd_mux[CAB_ST_CYC_LSB +: 3] = s_q.last_cyc;
            rd_mux[CAB_ST_SP_LSB +: 3]  = s_q.sp;
            read_only                   = 1'b1;
         end
         default: known = 1'b0;
      endcase
   end

   // bus slave, launch and commit
   always_comb
   begin
      s_d     = s_q;
      setup   = psel & ~penable;
      access  = psel & penable & s_q.pready;
      // no wait state: answer is prepared in the setup cycle
      s_d.pready = setup;
      // error flag stands only beside ready, never left over
      s_d.pslverr = 1'b0;
      if (setup)
      begin
         s_d.prdata  = pwrite ? 32'h0000_0000 : rd_mux;
         // a busy datapath refuses writes so operands cannot shift mid-op
         s_d.pslverr = ~known | (pwrite & (read_only | s_q.busy));
      end
      if (access & pwrite & ~s_q.pslverr)
      begin
         unique case (paddr)
            CAB_ADDR_CMD:
            begin
               s_d.op       = cab_op_t'(pwdata[CAB_CMD_OP_LSB +: 6]);
               s_d.bsel     = pwdata[CAB_CMD_BIT_LSB +: 3];
               s_d.two_word = pwdata[CAB_CMD_TWO_POS];
               s_d.io_a     = pwdata[CAB_CMD_IO_LSB +: 5];
               s_d.busy     = 1'b1;
               s_d.cnt      = 3'd1;
            end
            CAB_ADDR_DEST:   s_d.dest   = pwdata[7:0];
            CAB_ADDR_SRC:    s_d.src    = pwdata[7:0];
            CAB_ADDR_OFFS:   s_d.offs   = pwdata[11:0];
            CAB_ADDR_ZPTR:   s_d.zptr   = pwdata[15:0];
            CAB_ADDR_STATUS: s_d.status = pwdata[7:0];
            CAB_ADDR_PC:     s_d.pc     = pwdata[21:0];
            default:         s_d.busy   = s_q.busy;
         endcase
      end
      if (s_q.busy)
      begin
         if (s_q.cnt == cyc)
         begin
            s_d.busy     = 1'b0;
            s_d.last_cyc = cyc;
            s_d.pc       = pc_next;
            if (wr_dest)
            begin
               s_d.dest   = alu_res;
               s_d.result = alu_res;
            end
            if (wr_flags)
               s_d.status = alu_status_register;
            if (s_q.op == flag_set_op || s_q.op == flag_clear_op)
               s_d.status[s_q.bsel] = (s_q.op == flag_set_op);
            if (pc_kind == cab_pc_rel_call || pc_kind == cab_pc_ptr_call)
            begin
               s_d.stack[s_q.sp] = s_q.pc + 22'd1;
               s_d.sp            = s_q.sp + 3'd1;
            end
            if (pc_kind == cab_pc_ret)
               s_d.sp = s_q.sp - 3'd1;
            if (s_q.op == interrupt_return_op)
               s_d.status[CAB_FLG_I] = 1'b1;
         end
         else
            s_d.cnt = s_q.cnt + 3'd1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign prdata  = s_q.prdata;
   assign pready  = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign io_addr = s_q.io_a;

endmodule // cab_exec_top
`default_nettype wire

// ===== logic/cab_pkg.sv
// Purpose: shared constants and types of the execution datapath
// Assumes: 8-bit operands, 22-bit program counter, APB register access
// Notes:   byte addresses are word aligned; reset clears every register
package cab_pkg;

   // register byte addresses
   localparam logic [7:0] CAB_ADDR_CMD    = 8'h00;
   localparam logic [7:0] CAB_ADDR_DEST   = 8'h04;
   localparam logic [7:0] CAB_ADDR_SRC    = 8'h08;
   localparam logic [7:0] CAB_ADDR_OFFS   = 8'h0c;
   localparam logic [7:0] CAB_ADDR_ZPTR   = 8'h10;
   localparam logic [7:0] CAB_ADDR_STATUS = 8'h14;
   localparam logic [7:0] CAB_ADDR_RESULT = 8'h18;
   localparam logic [7:0] CAB_ADDR_PC     = 8'h1c;
   localparam logic [7:0] CAB_ADDR_STATE  = 8'h20;

   // command register field positions
   localparam int CAB_CMD_OP_LSB  = 0;
   localparam int CAB_CMD_BIT_LSB = 8;
   localparam int CAB_CMD_TWO_POS = 12;
   localparam int CAB_CMD_IO_LSB  = 16;
   // state register field positions
   localparam int CAB_ST_BUSY_POS = 0;
   localparam int CAB_ST_CYC_LSB  = 4;
   localparam int CAB_ST_SP_LSB   = 8;

   // status_register bit positions
   localparam int CAB_FLG_C = 0;
   localparam int CAB_FLG_Z = 1;
   localparam int CAB_FLG_N = 2;
   localparam int CAB_FLG_V = 3;
   localparam int CAB_FLG_S = 4;
   localparam int CAB_FLG_H = 5;
   localparam int CAB_FLG_T = 6;
   localparam int CAB_FLG_I = 7;

   // execution lengths in clock cycles
   localparam logic [2:0] CAB_CYC_ONE      = 3'd1;
   localparam logic [2:0] CAB_CYC_JUMP     = 3'd2;
   localparam logic [2:0] CAB_CYC_CALL     = 3'd3;
   localparam logic [2:0] CAB_CYC_RET      = 3'd4;
   localparam logic [2:0] CAB_CYC_BR_TAKEN = 3'd2;
   localparam logic [2:0] CAB_CYC_SKIP_ONE = 3'd2;
   localparam logic [2:0] CAB_CYC_SKIP_TWO = 3'd3;

   typedef enum logic [5:0] {
      no_op, add_op, add_carry_op, sub_op, sub_imm_op, sub_carry_op,
      sub_imm_with_carry_op, and_op, and_imm_op, or_op, or_imm_op, xor_op,
      ones_complement_op, twos_complement_op, set_bits_mask_op,
      clear_bits_mask_op, increment_op, decrement_op, test_op,
      clear_reg_op, set_reg_op, relative_jump_op, pointer_jump_op,
      relative_call_op, pointer_call_op, sub_return_op,
      interrupt_return_op, compare_skip_equal_op, compare_op,
      compare_carry_op, compare_imm_op, reg_bit_clear_skip_op,
      reg_bit_set_skip_op, io_bit_clear_skip_op, io_bit_set_skip_op,
      flag_set_branch_op, flag_clear_branch_op, signed_ge_branch_op,
      signed_lt_branch_op, unsigned_ge_branch_op, unsigned_lt_branch_op,
      shift_left_op, shift_right_op, rotate_left_op, rotate_right_op,
      arith_right_shift_op, swap_nibbles_op, flag_set_op, flag_clear_op
   } cab_op_t;

   typedef enum logic [3:0] {
      cab_alu_pass, cab_alu_add, cab_alu_sub, cab_alu_and, cab_alu_or,
      cab_alu_xor, cab_alu_com, cab_alu_inc, cab_alu_dec, cab_alu_shl,
      cab_alu_shr, cab_alu_asr, cab_alu_swap
   } cab_alu_t;

   typedef enum logic [2:0] {
      cab_pc_seq, cab_pc_rel, cab_pc_cond_rel, cab_pc_ptr, cab_pc_rel_call,
      cab_pc_ptr_call, cab_pc_ret, cab_pc_skip
   } cab_pc_t;

endpackage

// ===== test/cab_exec_props.sv
// Purpose: port-level checks of the execution datapath's register bus
// Assumes: no wait state on any transfer
// Notes:   operation results are judged by the bench, not here
`timescale 1ns/1ps
`default_nettype none
module cab_exec_props
   import cab_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [7:0]  io_rdata,
   input wire logic [4:0]  io_addr
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   unmapped_read_a: assert property (pready && paddr > CAB_ADDR_STATE
      |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
   ro_write_err_a: assert property (pready && pwrite && (paddr ==
      CAB_ADDR_RESULT || paddr == CAB_ADDR_STATE) |-> pslverr)
      else $error("read-only write accepted");
   io_addr_hold_a: assert property ($changed(io_addr) |->
      $past(pready && pwrite && paddr == CAB_ADDR_CMD))
      else $error("io address moved without command");
   pc_upper_zero_a: assert property (pready && paddr == CAB_ADDR_PC
      |-> prdata[31:22] == 10'h0) else $error("pc upper bits set");
   cover property (pready && pwrite && paddr == CAB_ADDR_CMD);
   cover property (pready && pslverr);
   cover property ($changed(io_addr));
endmodule // cab_exec_props
bind cab_exec_top cab_exec_props u_props (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .io_rdata, .io_addr);
`default_nettype wire

// ===== test/cab_io_model.sv
// Purpose: I/O register space seen by the io-bit skip operations
// Assumes: reads are combinational from the addressed location
// Notes:   contents follow the address, so each location differs
`timescale 1ns/1ps
`default_nettype none
module cab_io_model
(
   input  wire logic [4:0] io_addr,
   output logic      [7:0] io_rdata
);
   // low bits inverted so neighbouring locations never read alike
   assign io_rdata = {io_addr, ~io_addr[2:0]};
endmodule // cab_io_model
`default_nettype wire

// ===== test/cpu_alu_branch_exec_test.sv
// Purpose: self-checking bench of the execution datapath
// Assumes: model values are set before each operation is launched
// Notes:   read data is taken at the edge that samples pready high
`timescale 1ns/1ps
`default_nettype none
module cpu_alu_branch_exec_test;
   import cab_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]  paddr, io_rdata, d, s, sr, r;
   logic [4:0]  io_addr;
   logic [31:0] pwdata, prdata, rd, lf, sm;
   logic [21:0] pc_m;
   logic [5:0]  f;
   int          err_total, checked, k;
   cab_exec_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .io_rdata, .io_addr);
   cab_io_model u_io (.io_addr, .io_rdata);
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   function automatic logic [13:0] ar(input logic [7:0] a, b,
      input logic ci, sb);
      logic [7:0] bb;
      logic [8:0] t;
      logic       h, v;
      bb = b ^ {8{sb}};
      t = a + bb + (sb | ci);
      h = ((a[3:0] + bb[3:0] + (sb | ci)) > 5'h0f) ^ sb;
      v = (a[7] == bb[7]) && (t[7] != a[7]);
      return {h, t[7] ^ v, v, t[7], t[7:0] == 8'h0, t[8] ^ sb, t[7:0]};
   endfunction
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task chk(input string n, input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, v};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task stop_test;
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task run(input cab_op_t op, input logic [31:0] x, input int cy,
      input logic [7:0] dm);
      apb(1'b1, CAB_ADDR_DEST, 32'(d));
      apb(1'b1, CAB_ADDR_SRC, 32'(s));
      apb(1'b1, CAB_ADDR_STATUS, 32'(sr));
      apb(1'b1, CAB_ADDR_CMD, x | 32'(op));
      do apb(1'b0, CAB_ADDR_STATE, 32'h0); while (rd[0] !== 1'b0);
      chk("cycles", 32'(rd[6:4]), 32'(cy));
      apb(1'b0, CAB_ADDR_PC, 32'h0);
      chk("pc", rd, 32'(pc_m));
      apb(1'b0, CAB_ADDR_STATUS, 32'h0);
      chk("status", rd, sm);
      apb(1'b0, CAB_ADDR_DEST, 32'h0);
      chk("dest", rd, 32'(dm));
   endtask
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      {lf, pc_m} = {32'hcaa94190, 22'h0};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped_err", 32'(er), 32'h1);
      for (int i = 0; i < 9; i++)
      begin
         lf = lfsr(lf);
         {sr, s, d} = lf[23:0];
         {f, r} = ar(d, s, i % 3 == 1 && sr[0], i % 3 == 2);
         sm = {sr[7:6], f};
         pc_m++;
         run(i % 3 == 0 ? add_op : (i % 3 == 1 ? add_carry_op : sub_op),
            32'h0, 1, r);
      end
      r = d & s;
      sm = {sr[7:5], r[7], 1'b0, r[7], r == 8'h0, sr[0]};
      pc_m++;
      run(and_op, 32'h0, 1, r);
      r = ~d;
      sm = {sr[7:5], r[7], 1'b0, r[7], r == 8'h0, 1'b1};
      pc_m++;
      run(ones_complement_op, 32'h0, 1, r);
      r = d + 8'h1;
      sm = {sr[7:5], r[7] ^ (r == 8'h80), r == 8'h80, r[7], r == 8'h0, sr[0]};
      pc_m++;
      run(increment_op, 32'h0, 1, r);
      r = d & ~s;
      sm = {sr[7:5], r[7], 1'b0, r[7], r == 8'h0, sr[0]};
      pc_m++;
      run(clear_bits_mask_op, 32'h0, 1, r);
      {f, r} = ar(d, s, 1'b0, 1'b1);
      sm = {sr[7:6], f};
      pc_m++;
      run(compare_op, 32'h0, 1, d);
      r = {d[6:0], sr[0]};
      sm = {sr[7:6], d[3], sr[4], r[7] ^ d[7], r[7], r == 8'h0, d[7]};
      pc_m++;
      run(rotate_left_op, 32'h0, 1, r);
      for (int b = 0; b < 2; b++)
      begin
         r = {b ? d[7] : sr[0], d[7:1]};
         sm = {sr[7:4], r[7] ^ d[0], r[7], r == 8'h0, d[0]};
         pc_m++;
         run(b ? arith_right_shift_op : rotate_right_op, 32'h0, 1,
            r);
      end
      sm = 32'(sr);
      apb(1'b1, CAB_ADDR_OFFS, 32'hffe);
      pc_m = pc_m - 22'h1;
      run(relative_jump_op, 32'h0, 2, d);
      apb(1'b1, CAB_ADDR_PC, 32'h3f0000);
      apb(1'b1, CAB_ADDR_ZPTR, 32'(lf[31:16]));
      pc_m = 22'(lf[31:16]);
      run(pointer_jump_op, 32'h0, 2, d);
      for (int b = 0; b < 2; b++)
      begin
         k = int'(b ? !sr[0] : !(sr[2] ^ sr[3]));
         pc_m = k ? pc_m - 22'h1 : pc_m + 22'h1;
         run(b ? unsigned_ge_branch_op : signed_ge_branch_op, 32'h0, 1 + k,
            d);
      end
      s = d;
      pc_m = pc_m + 22'h3;
      run(compare_skip_equal_op, 32'h1000, 3, d);
      s = ~d;
      pc_m++;
      run(compare_skip_equal_op, 32'h1000, 1, d);
      for (int b = 0; b < 2; b++)
      begin
         k = 32'((8'h55 >> b) & 8'h1);
         pc_m = pc_m + 22'(1 + k);
         run(io_bit_set_skip_op, 32'h0a0000 | 32'(b << 8), 1 + k, d);
      end
      k = int'(!d[3]);
      pc_m = pc_m + 22'(1 + k);
      run(reg_bit_clear_skip_op, 32'h300, 1 + k, d);
      k = 32'(pc_m) + 1;
      pc_m = 22'(lf[31:16]);
      run(pointer_call_op, 32'h0, 3, d);
      pc_m = 22'(k);
      run(sub_return_op, 32'h0, 4, d);
      k = 32'(pc_m) + 1;
      pc_m = pc_m - 22'h1;
      run(relative_call_op, 32'h0, 3, d);
      pc_m = 22'(k);
      sm = 32'({1'b1, sr[6:0]});
      run(interrupt_return_op, 32'h0, 4, d);
      sm = 32'({sr[7], 1'b1, sr[5:0]});
      pc_m++;
      run(flag_set_op, 32'h600, 1, d);
      stop_test;
   end
   initial
   begin
      repeat (20000) @(posedge pclk);
      err_total++;
      stop_test;
   end
endmodule // cpu_alu_branch_exec_test
`default_nettype wire
